// file: rtl/otp_cal_pkg.sv
// Constants shared by the calibration store logic.
package otp_cal_pkg;
  localparam int SR_BITS = 9;
  localparam int OFS_MSB = 8;
  localparam int OFS_LSB = 4;
  localparam int TC_MSB = 3;
  localparam int TC_LSB = 1;
  localparam int SEAL_POS = 0;
  localparam logic [8:0] SR_RESET = 9'h000;
  localparam logic [7:0] VSET_RESET = 8'h00;
  localparam logic [1:0] PC_RESET = 2'h0;
  localparam logic PSAVE_RESET = 1'b1;
  localparam logic [7:0] CMD_CAL_ENTER = 8'h82;
  localparam logic [7:0] CMD_PC_MASK = 8'hf9;
  localparam logic [7:0] CMD_PC_CODE = 8'h29;
  localparam int CMD_CONT_POS = 7;
  localparam int CMD_DATA_POS = 0;
  localparam int PC_LSB = 1;
  localparam logic [9:0] CLAMP_HI = 10'h0ff;
  localparam logic [7:0] VMAX = 8'hff;
  localparam logic [7:0] VMIN = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_VSET = 8'h04;
  localparam logic [7:0] ADDR_PSAVE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_RESULT = 8'h10;
  localparam int RELOAD_TIME_MS = 5;
  localparam int CLK_MHZ = 200;
  localparam int RELOAD_CYCLES = RELOAD_TIME_MS * 1000 * CLK_MHZ;
endpackage : otp_cal_pkg

// file: rtl/otp_cal_store.sv
// Calibration shift register, reload sequencer, clamping adder and AHB-Lite registers.
// Function
// - Nine bits: offset, coefficient, seal
// - Offset is signed, added to voltage
// - Sum clamps to 255 and 0
// - Stored coefficient is basic default coefficient
// - Seal zero allows, one disables calibration
// - Programmed seal never reverts
// - Programming voltage ignored outside calibration
// - Cells reached only via flip-flops
// - Read copies cells into shift register
// - Write shifts nine bits, then programs
// - Shifted values act on output immediately
// - Reload on power-save exit, refresh; 5 ms
// - One bit shifted per command byte
// - After exit, normal decoding resumes
// - Reset clears all flip-flops except power-save, which it sets
// - Entry ignored until refresh completes
// - Bits arrive MSB first, seal last
// - Entry ignored when sealed; reset exits
// - D7 continues, D0 is data
// - Power control in power-save: no reload
// - Power control command triggers reload
`timescale 1ns/1ps
module otp_cal_store #(
  parameter int RELOAD_CYCLES = otp_cal_pkg::RELOAD_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [4:0] pin_voltage_offset_i,
  input wire logic [8:0] otp_cells_i,
  input wire logic prog_voltage_i,
  output logic [8:0] otp_program_o,
  output logic [7:0] voltage_programming_value_o,
  output logic [2:0] stored_temp_coeff_default_o,
  output logic [1:0] power_control_bits_o,
  output logic calibration_mode_o
);
  logic [1:0] rst_sync;
  logic rst_n;
  logic [4:0] pin_m, pin_s;
  logic [8:0] cells_m, cells_s;
  logic prog_m, prog_s;
  logic [8:0] shift_reg;
  logic calibration_mode;
  logic refresh_done;
  logic reload_busy;
  logic [31:0] reload_cnt;
  logic [7:0] voltage_setting;
  logic power_save;
  logic [1:0] power_control_bits;
  logic wr_q;
  logic [7:0] addr_q;
  logic [7:0] vpv;

  // Reset is applied at once but released only after two clean edges, so no flip-flop leaves reset mid-edge.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // Cell contents, the offset pins and the programming supply sense come from outside the clock.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_m <= 5'h00;
      pin_s <= 5'h00;
      cells_m <= 9'h000;
      cells_s <= 9'h000;
      prog_m <= 1'b0;
      prog_s <= 1'b0;
    end else begin
      pin_m <= pin_voltage_offset_i;
      pin_s <= pin_m;
      cells_m <= otp_cells_i;
      cells_s <= cells_m;
      prog_m <= prog_voltage_i;
      prog_s <= prog_m;
    end
  end

  // Bus slave: zero wait states, registered read data.
  wire addr_ok = hsel_i && htrans_i[1] && hready_i;
  wire [7:0] haddr_lo = haddr_i[7:0];
  wire cmd_wr = wr_q && (addr_q == otp_cal_pkg::ADDR_CMD);
  wire vset_wr = wr_q && (addr_q == otp_cal_pkg::ADDR_VSET);
  wire psave_wr = wr_q && (addr_q == otp_cal_pkg::ADDR_PSAVE);
  wire [7:0] cmd = hwdata_i[7:0];
  wire [31:0] status_word = {16'h0000, 2'h0, power_control_bits, power_save, reload_busy,
                             refresh_done, calibration_mode, shift_reg[7:0]} | {23'h0, shift_reg[8], 8'h00};
  wire [31:0] rd_mux = (haddr_lo == otp_cal_pkg::ADDR_VSET) ? {24'h0, voltage_setting} :
                       (haddr_lo == otp_cal_pkg::ADDR_PSAVE) ? {31'h0, power_save} :
                       (haddr_lo == otp_cal_pkg::ADDR_STATUS) ? status_word :
                       (haddr_lo == otp_cal_pkg::ADDR_RESULT) ? {21'h0, stored_temp_coeff_default_o, vpv} :
                       32'h0;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_o <= 32'h0;
    end else begin
      wr_q <= addr_ok && hwrite_i;
      addr_q <= haddr_lo;
      hrdata_o <= (addr_ok && !hwrite_i) ? rd_mux : 32'h0;
    end
  end

  // Command decode; while in calibration mode every byte is shift data.
  wire cal_byte = cmd_wr && calibration_mode;
  wire enter_cmd = cmd_wr && !calibration_mode && (cmd == otp_cal_pkg::CMD_CAL_ENTER);
  wire enter_ok = enter_cmd && refresh_done && !shift_reg[otp_cal_pkg::SEAL_POS];
  wire pc_cmd = cmd_wr && !calibration_mode &&
                ((cmd & otp_cal_pkg::CMD_PC_MASK) == otp_cal_pkg::CMD_PC_CODE);
  // Leaving power-save is the second reload trigger; a write that keeps power-save set starts nothing.
  wire psave_exit = psave_wr && power_save && !hwdata_i[0];
  wire reload_start = (pc_cmd && !power_save) || psave_exit;
  wire reload_last = reload_busy && (reload_cnt == 32'(RELOAD_CYCLES - 1));

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) calibration_mode <= 1'b0;
    else if (enter_ok) calibration_mode <= 1'b1;
    else if (cal_byte && !cmd[otp_cal_pkg::CMD_CONT_POS]) calibration_mode <= 1'b0;
  end

  // Parallel reload wins over a shift; the first serial bit ends in offset bit 4.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) shift_reg <= otp_cal_pkg::SR_RESET;
    else if (reload_start) shift_reg <= cells_s;
    else if (cal_byte) shift_reg <= {shift_reg[7:0], cmd[otp_cal_pkg::CMD_DATA_POS]};
  end

  // The cells are copied at once; the busy window only times the slow read of the cells.
  // A new trigger during the window restarts it, and the done flag never clears until reset.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reload_busy <= 1'b0;
      reload_cnt <= 32'h0;
      refresh_done <= 1'b0;
    end else if (reload_start) begin
      reload_busy <= 1'b1;
      reload_cnt <= 32'h0;
    end else if (reload_last) begin
      reload_busy <= 1'b0;
      refresh_done <= 1'b1;
    end else if (reload_busy) begin
      reload_cnt <= reload_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      voltage_setting <= otp_cal_pkg::VSET_RESET;
      power_save <= otp_cal_pkg::PSAVE_RESET;
      power_control_bits <= otp_cal_pkg::PC_RESET;
    end else begin
      if (vset_wr) voltage_setting <= hwdata_i[7:0];
      if (psave_wr) power_save <= hwdata_i[0];
      if (pc_cmd) power_control_bits <= cmd[otp_cal_pkg::PC_LSB +: 2];
    end
  end

  // Signed offsets extend to ten bits; the sum clamps at both ends.
  wire [4:0] stored_voltage_offset = shift_reg[otp_cal_pkg::OFS_MSB:otp_cal_pkg::OFS_LSB];
  wire [9:0] sum = {{5{pin_s[4]}}, pin_s} + {{5{stored_voltage_offset[4]}}, stored_voltage_offset} +
                   {2'h0, voltage_setting};
  wire under = sum[9];
  wire over = !sum[9] && (sum > otp_cal_pkg::CLAMP_HI);
  assign vpv = under ? otp_cal_pkg::VMIN : over ? otp_cal_pkg::VMAX : sum[7:0];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      voltage_programming_value_o <= otp_cal_pkg::VMIN;
      stored_temp_coeff_default_o <= 3'h0;
    end else begin
      voltage_programming_value_o <= vpv;
      stored_temp_coeff_default_o <= shift_reg[otp_cal_pkg::TC_MSB:otp_cal_pkg::TC_LSB];
    end
  end

  // Each slice drives its own cell, and a cell is burned only while its flip-flop holds a one.
  // The supply sense is synchronised through two flip-flops, so a glitch caught at a clock edge still reaches the cells two cycles later.
  wire prog_window = calibration_mode && prog_s;
  genvar slice;
  generate
    for (slice = 0; slice < otp_cal_pkg::SR_BITS; slice++) begin : g_slice
      always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) otp_program_o[slice] <= 1'b0;
        else otp_program_o[slice] <= prog_window && shift_reg[slice];
      end
    end
  endgenerate
  assign power_control_bits_o = power_control_bits;
  assign calibration_mode_o = calibration_mode;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  sequence s_enter_req;
    enter_cmd && !calibration_mode;
  endsequence

  a_seal_blocks_entry: assert property (s_enter_req and shift_reg[0] |=> !calibration_mode)
    else $error("calibration mode entered while sealed");
  a_entry_needs_refresh: assert property (s_enter_req and !refresh_done |=> !calibration_mode)
    else $error("calibration mode entered before refresh");
  a_entry_allowed: assert property (s_enter_req and refresh_done && !shift_reg[0] |=> calibration_mode)
    else $error("valid entry command refused");
  a_program_gated: assert property (otp_program_o != 9'h000 |-> $past(calibration_mode) && $past(prog_s))
    else $error("cell programmed outside calibration mode");
  a_shift_one_bit: assert property (cal_byte && !reload_start |=> shift_reg == {$past(shift_reg[7:0]),
                                    $past(cmd[0])})
    else $error("shift register did not take one bit");
  a_exit_on_clear: assert property (cal_byte && !cmd[7] |=> !calibration_mode)
    else $error("calibration mode kept after cleared continuation");
  a_reload_copies: assert property (reload_start |=> shift_reg == $past(cells_s) ##0 reload_busy)
    else $error("reload did not copy the cells");
  a_reload_bound: assert property (reload_busy |-> reload_cnt < 32'(RELOAD_CYCLES))
    else $error("reload took too long");
  a_clamp_high: assert property (over |=> voltage_programming_value_o == otp_cal_pkg::VMAX)
    else $error("overflow not clamped to maximum");
  a_clamp_low: assert property (under |=> voltage_programming_value_o == otp_cal_pkg::VMIN)
    else $error("underflow not clamped to zero");
  a_save_no_reload: assert property (pc_cmd && power_save && !psave_exit |=> !$rose(reload_busy) &&
                                     power_control_bits == $past(cmd[2:1]))
    else $error("power control in power-save mishandled");

  // Leaving calibration mode takes a data byte with its continuation bit clear.
  sequence s_exit_byte;
    cal_byte && !cmd[otp_cal_pkg::CMD_CONT_POS];
  endsequence

  // Either reload trigger starts the same timed window.
  sequence s_reload_req;
    reload_start;
  endsequence

  // The mode may only rise through an accepted entry command.
  a_mode_rise_cause: assert property ($rose(calibration_mode) |-> $past(enter_ok))
    else $error("calibration mode rose without an accepted entry");
  // The mode may only fall through a data byte that ends the mode.
  a_mode_fall_cause: assert property ($fell(calibration_mode) |-> $past(cal_byte) && !$past(cmd[7]))
    else $error("calibration mode dropped without an exit byte");
  // The exit byte still shifts its data bit in on the same edge where the mode drops.
  a_exit_shifts: assert property (s_exit_byte |=> shift_reg[0] == $past(cmd[0]))
    else $error("exit byte did not shift its data bit");
  // A reload opens a fresh window with the counter at zero.
  a_reload_starts: assert property (s_reload_req |=> reload_busy && reload_cnt == 32'h0)
    else $error("reload window did not open");
  // The window counts one step per cycle until it ends.
  a_busy_counts: assert property (reload_busy && !reload_last && !reload_start |=>
                                  reload_cnt == $past(reload_cnt) + 32'h1)
    else $error("reload counter skipped");
  // Once a reload has finished, entry permission stays decided.
  a_done_sticky: assert property (refresh_done |=> refresh_done)
    else $error("refresh done flag cleared");
  // The coefficient output follows its flip-flops one cycle later.
  a_tc_follows: assert property (1'b1 |=> stored_temp_coeff_default_o == $past(shift_reg[3:1]))
    else $error("coefficient output does not follow the shift register");
  // Without a clamp the output is the plain sum.
  a_sum_passes: assert property (!over && !under |=> voltage_programming_value_o == $past(sum[7:0]))
    else $error("unclamped sum not passed through");
  // The shift register moves only by a reload or a data byte.
  a_shift_holds: assert property (!cal_byte && !reload_start |=> shift_reg == $past(shift_reg))
    else $error("shift register changed without cause");
  // Only slices that hold a one are ever programmed.
  a_prog_needs_one: assert property (1'b1 |=> (otp_program_o & ~$past(shift_reg)) == 9'h000)
    else $error("cell programmed while its flip-flop held zero");
  // Every power control command updates the power control bits.
  a_pc_updates: assert property (pc_cmd |=> power_control_bits == $past(cmd[2:1]))
    else $error("power control bits not updated");
endmodule : otp_cal_store

// file: verif/otp_cal_store_tb.sv
// Self-checking bench for the calibration store.
`timescale 1ns/1ps
module otp_cal_store_tb;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, prog = 0, ld = 1, hrdy, hresp, cal;
  logic [1:0] htrans = 0, pcb;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [4:0] pins = 0;
  logic [8:0] cells, preset = 0, prg;
  logic [7:0] vpv;
  logic [2:0] tc;
  logic [15:0] lf = 16'hf2b4, r;
  int fails = 0, n_compared = 0, sr = 0, cm = 0, vs = 0, cl = 0, cyc = 0;
  int bitq[$];
  always #2.5 clk = ~clk;
  otp_cal_store #(.RELOAD_CYCLES(8)) dut_u (.clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .pin_voltage_offset_i(pins), .otp_cells_i(cells), .prog_voltage_i(prog),
    .otp_program_o(prg), .voltage_programming_value_o(vpv), .stored_temp_coeff_default_o(tc),
    .power_control_bits_o(pcb), .calibration_mode_o(cal));
  otp_cell_model cell_u (.clk_i(clk), .program_i(prg), .preset_i(preset), .load_i(ld), .cells_o(cells));
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction : rnd
  function automatic int clampv(input int p, input int o, input int v);
    int s;
    s = (p > 15 ? p - 32 : p) + (o > 15 ? o - 32 : o) + v;
    return s < 0 ? 0 : (s > 255 ? 255 : s);
  endfunction : clampv
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus
  task automatic check_all();
    int e;
    repeat (4) @(posedge clk);
    e = clampv(pins, (sr >> 4) & 31, vs);
    bus(1'b0, 8'h10, 0);
    chk("result", e | (((sr >> 1) & 7) << 8), rd[10:0]);
    chk("vout", e, vpv);
    chk("coeff", (sr >> 1) & 7, tc);
    bus(1'b0, 8'h0c, 0);
    chk("sreg", sr & 255, rd[7:0]);
    chk("calmode", cm, cal);
    chk("okay", 32'h2, {hrdy, hresp});
  endtask : check_all
  task automatic shift9(input logic [8:0] v, input logic stay);
    for (int k = 8; k >= 0; k--) begin
      r = rnd();
      bus(1'b1, 8'h00, {24'h0, stay || k > 0, r[5:0], v[k]});
      bitq.push_back(v[k]);
      sr = ((sr << 1) | bitq.pop_front()) & 511;
      cm = stay || k > 0;
      check_all();
    end
  endtask : shift9
  task automatic reload(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    bus(1'b0, 8'h0c, 0);
    chk("busy", 1, rd[10]);
    for (int i = 0; i < 20 && rd[10] !== 1'b0; i++) bus(1'b0, 8'h0c, 0);
    chk("done", 1, rd[10:9]);
    sr = cl;
  endtask : reload
  task automatic burn();
    prog <= 1'b1;
    repeat (5) @(posedge clk);
    chk("program", sr, prg);
    cl = cl | sr;
    prog <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : burn
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    r = rnd();
    preset = {r[8:1], 1'b0};
    cl = preset;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    ld <= 1'b0;
    repeat (3) @(posedge clk);
    check_all();
    bus(1'b1, 8'h00, 32'h82);
    check_all();
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      pins <= r[15:11];
      vs = (i == 0) ? 0 : (i == 1) ? 255 : r[7:0];
      bus(1'b1, 8'h04, vs);
      if (i == 2) reload(8'h08, 0);
      check_all();
    end
    bus(1'b1, 8'h00, 32'h82);
    cm = 1;
    r = rnd();
    shift9({r[8:1], 1'b0}, 1'b1);
    burn();
    shift9(9'h000, 1'b0);
    prog <= 1'b1;
    repeat (5) @(posedge clk);
    chk("noprog", 0, prg);
    prog <= 1'b0;
    repeat (5) @(posedge clk);
    bus(1'b1, 8'h00, 32'h82);
    cm = 1;
    shift9(9'h001, 1'b1);
    burn();
    shift9(9'h000, 1'b0);
    reload(8'h00, 32'h2d);
    chk("cells", cl, cells);
    chk("pcbits", 2'h2, pcb);
    bus(1'b1, 8'h00, 32'h82);
    check_all();
    bus(1'b1, 8'h08, 1);
    bus(1'b1, 8'h00, 32'h2b);
    bus(1'b0, 8'h0c, 0);
    chk("noreload", 0, rd[10]);
    chk("pcbits", 2'h1, pcb);
    wrap_up();
  end
endmodule : otp_cal_store_tb

// file: verif/otp_cell_model.sv
// Behavioural model of the nine one-time-programmable cells.
`timescale 1ns/1ps
module otp_cell_model (
  input wire logic clk_i,
  input wire logic [8:0] program_i,
  input wire logic [8:0] preset_i,
  input wire logic load_i,
  output logic [8:0] cells_o
);
  initial cells_o = 9'h000;
  always @(posedge clk_i) begin
    if (load_i) begin
      cells_o <= preset_i;
    end else begin
      // A programmed cell only ever gains ones, so nothing can be undone.
      cells_o <= cells_o | program_i;
    end
  end
endmodule : otp_cell_model
